// >>> logic/sipol_top.sv
// serial-in parallel-out shift register with storage register
// assumes pin inputs are asynchronous to sys_clk_i and are synchronised here
// Functional notes
// - eight shift stages feed an eight-bit storage register.
// - only rising clock edges and low clear levels change state; clock levels and falls do nothing.
// - with tied clocks, storage takes the shift contents from before the edge.
// - shift clear low forces all shift stages to zero.
// - shift rise with data low loads zero into stage one, others move.
// - shift rise with data high loads one into stage one, others move.
// - both registers start at zero after power-up clearing.
// - parallel outputs change only by storage clock or storage clear.
`timescale 1ns/1ps
`default_nettype none
`include "sipol_map.svh"
module sipol_top (
  input wire logic sys_clk_i, // 20 MHz clock
  input wire logic rst_i, // sync reset, active high
  input wire logic ce_i, // clock enable
  input wire logic serial_in_i, // serial data pin
  input wire logic shift_clock_i, // shift clock pin
  input wire logic shift_clear_n_i, // shift clear pin, active low
  input wire logic storage_clock_i, // storage clock pin
  input wire logic storage_clear_n_i, // storage clear pin, active low
  input wire logic hold_i, // stall applying queued events
  output logic [`SIPOL_STAGES-1:0] parallel_out_o, // stored word
  output logic cascade_out_o, // last shift stage
  output logic in_ready_o // event queue has room
);
  logic [`SIPOL_PIN_W-1:0] pin_s1;
  logic [`SIPOL_PIN_W-1:0] pin_s2;
  logic [`SIPOL_PIN_W-1:0] pin_d;
  sipol_pkg::sipol_event_s ev_in;
  sipol_pkg::sipol_event_s ev_out;
  logic ev_push;
  logic ev_valid;
  logic ev_pop;
  logic fifo_ready;
  sipol_pkg::sipol_word_t shift;
  sipol_pkg::sipol_word_t next_shift;

  // rising edge of a synchronised level
  function automatic logic edge_up(input logic now_v, input logic was_v);
    return now_v && !was_v;
  endfunction

  // two-flop synchroniser, clears in the top bits, then one stage for edges
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_s1 <= `SIPOL_PIN_RST;
      pin_s2 <= `SIPOL_PIN_RST;
      pin_d <= `SIPOL_PIN_RST;
    end else if (ce_i) begin
      pin_s1 <= {shift_clear_n_i, storage_clear_n_i, serial_in_i,
                 shift_clock_i, storage_clock_i};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // rising clock edges and changes on either clear pin become events
  always_comb begin
    ev_in.shift_clear_n = pin_s2[`SIPOL_PIN_SH_CLR];
    ev_in.storage_clear_n = pin_s2[`SIPOL_PIN_ST_CLR];
    ev_in.serial_in = pin_s2[`SIPOL_PIN_DATA];
    ev_in.shift_rise = edge_up(pin_s2[`SIPOL_PIN_SH_CLK], pin_d[`SIPOL_PIN_SH_CLK]);
    ev_in.storage_rise = edge_up(pin_s2[`SIPOL_PIN_ST_CLK], pin_d[`SIPOL_PIN_ST_CLK]);
    ev_push = ev_in.shift_rise || ev_in.storage_rise ||
      (pin_s2[`SIPOL_PIN_CLRS] != pin_d[`SIPOL_PIN_CLRS]);
  end

  sipol_fifo #(
    .WIDTH($bits(sipol_pkg::sipol_event_s)),
    .DEPTH(`SIPOL_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_data_i(ev_in),
    .in_valid_i(ev_push),
    .in_ready_o(fifo_ready),
    .out_data_o(ev_out),
    .out_valid_o(ev_valid),
    .out_ready_i(!hold_i)
  );

  assign ev_pop = ce_i && ev_valid && !hold_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_ready_o <= 1'b0;
    end else if (ce_i) begin
      in_ready_o <= fifo_ready;
    end
  end

  // shift stage next value
  always_comb begin
    next_shift = shift;
    if (!ev_out.shift_clear_n) begin
      next_shift = `SIPOL_ZERO;
    end else if (ev_out.shift_rise) begin
      next_shift = {shift[`SIPOL_STAGES-2:0], ev_out.serial_in};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shift <= `SIPOL_ZERO;
      cascade_out_o <= 1'b0;
    end else if (ev_pop) begin
      shift <= next_shift;
      cascade_out_o <= next_shift[`SIPOL_STAGES-1];
    end
  end

  // storage register sees the old shift word on a shared event
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      parallel_out_o <= `SIPOL_ZERO;
    end else if (ev_pop) begin
      if (!ev_out.storage_clear_n) begin
        parallel_out_o <= `SIPOL_ZERO;
      end else if (ev_out.storage_rise) begin
        parallel_out_o <= shift;
      end
    end
  end

  chk_reset_zero: assert property (@(posedge sys_clk_i)
    rst_i |=> (parallel_out_o == `SIPOL_ZERO) && (shift == `SIPOL_ZERO))
    else $error("reset did not clear registers");

  chk_shift_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && !ev_out.shift_clear_n) |=> (shift == `SIPOL_ZERO) && !cascade_out_o)
    else $error("shift clear did not zero stages");

  chk_shift_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && ev_out.shift_rise && !ev_out.serial_in)
    |=> (shift == {$past(shift[`SIPOL_STAGES-2:0]), 1'b0}))
    else $error("shift with low data wrong");

  chk_shift_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && ev_out.shift_rise && ev_out.serial_in)
    |=> (shift == {$past(shift[`SIPOL_STAGES-2:0]), 1'b1}))
    else $error("shift with high data wrong");

  chk_no_edge_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && !ev_out.shift_rise) |=> $stable(shift))
    else $error("shift changed without rising edge");

  chk_store_lag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.storage_clear_n && ev_out.storage_rise && ev_out.shift_rise)
    |=> (parallel_out_o == $past(shift)) && (parallel_out_o != shift || $stable(shift)))
    else $error("storage did not lag shift");

  chk_store_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(ev_pop && (ev_out.storage_rise || !ev_out.storage_clear_n)) |=> $stable(parallel_out_o))
    else $error("outputs changed without storage event");

  chk_store_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && !ev_out.storage_clear_n) |=> (parallel_out_o == `SIPOL_ZERO))
    else $error("storage clear failed");

  chk_cascade_tap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cascade_out_o == shift[`SIPOL_STAGES-1])
    else $error("cascade output not last stage");

  chk_pin_to_shift: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && ev_out.shift_rise) ##1
    (ev_pop && ev_out.shift_clear_n && ev_out.shift_rise)
    |=> shift[1:0] == {$past(ev_out.serial_in, 2), $past(ev_out.serial_in)})
    else $error("stages not chained");

  chk_freeze_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(shift) && $stable(parallel_out_o) &&
    $stable(cascade_out_o) && $stable(pin_s2))
    else $error("state moved while clock enable low");

  chk_store_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.storage_clear_n && ev_out.storage_rise)
    |=> (parallel_out_o == $past(shift)))
    else $error("storage did not load shift stages");

  chk_clear_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && !ev_out.shift_clear_n && ev_out.shift_rise) |=> (shift == `SIPOL_ZERO))
    else $error("shift clock beat shift clear");

  chk_store_clr_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && !ev_out.storage_clear_n && ev_out.storage_rise)
    |=> (parallel_out_o == `SIPOL_ZERO))
    else $error("storage clock beat storage clear");

  chk_store_keeps_shift: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && ev_out.storage_rise && !ev_out.shift_rise)
    |=> $stable(shift))
    else $error("storage clock moved shift stages");

  chk_ready_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> !in_ready_o)
    else $error("ready high during reset");

  chk_cascade_reset: assert property (@(posedge sys_clk_i)
    rst_i |=> !cascade_out_o)
    else $error("cascade high during reset");

  chk_cascade_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && !ev_out.shift_rise) |=> $stable(cascade_out_o))
    else $error("cascade changed without shift");

  chk_fall_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pin_d[`SIPOL_PIN_SH_CLK] && !pin_s2[`SIPOL_PIN_SH_CLK] && !ev_in.storage_rise &&
    (pin_s2[`SIPOL_PIN_CLRS] == pin_d[`SIPOL_PIN_CLRS])) |-> !ev_push)
    else $error("falling clock made an event");

  chk_stage_chain: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && ev_out.shift_rise)
    |=> (shift[`SIPOL_STAGES-1:1] == $past(shift[`SIPOL_STAGES-2:0])))
    else $error("stages did not move up");

  chk_first_stage: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ev_pop && ev_out.shift_clear_n && ev_out.shift_rise)
    |=> (shift[0] == $past(ev_out.serial_in)))
    else $error("first stage missed serial data");

  chk_idle_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !ev_pop |=> $stable(parallel_out_o) && $stable(shift))
    else $error("state changed with no event");
endmodule
`default_nettype wire

// >>> logic/sipol_map.svh
// constants for the serial-in parallel-out latch
// assumes inclusion by every file of the block
`ifndef SIPOL_MAP_SVH
`define SIPOL_MAP_SVH
`define SIPOL_STAGES 8
`define SIPOL_FIFO_DEPTH 16
`define SIPOL_ZERO 8'h00
`define SIPOL_PIN_RST 5'h18
`define SIPOL_PIN_W 5
`define SIPOL_PIN_SH_CLR 4
`define SIPOL_PIN_ST_CLR 3
`define SIPOL_PIN_CLRS 4:3
`define SIPOL_PIN_DATA 2
`define SIPOL_PIN_SH_CLK 1
`define SIPOL_PIN_ST_CLK 0
`endif

// >>> logic/sipol_pkg.sv
// types for the serial-in parallel-out latch
// assumes sipol_map.svh is on the include path
`default_nettype none
`include "sipol_map.svh"
package sipol_pkg;
  typedef logic [`SIPOL_STAGES-1:0] sipol_word_t;
  // one sampled pin event, carried through the fifo
  typedef struct packed {
    logic shift_clear_n;
    logic storage_clear_n;
    logic serial_in;
    logic shift_rise;
    logic storage_rise;
  } sipol_event_s;
endpackage
`default_nettype wire

// >>> logic/sipol_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sipol_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic [WIDTH-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // not full
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic out_valid_o, // not empty
  input wire logic out_ready_i // read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/sipol_host_model.sv
// host pin driver for the serial-in parallel-out latch
// assumes tasks are called by the bench just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module sipol_host_model (
  input wire logic clk_i, // bench clock
  output logic serial_in_o, // data pin
  output logic shift_clock_o, // shift clock pin
  output logic shift_clear_n_o, // shift clear pin
  output logic storage_clock_o, // storage clock pin
  output logic storage_clear_n_o // storage clear pin
);
  initial begin
    serial_in_o = 1'b0;
    shift_clock_o = 1'b0;
    shift_clear_n_o = 1'b1;
    storage_clock_o = 1'b0;
    storage_clear_n_o = 1'b1;
  end
  // each level held past the two-stage synchroniser
  task automatic gap();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic shift_bit(input logic bit_v, input logic tie);
    serial_in_o <= bit_v;
    gap();
    shift_clock_o <= 1'b1;
    storage_clock_o <= tie;
    gap();
    shift_clock_o <= 1'b0;
    storage_clock_o <= 1'b0;
    gap();
  endtask
  task automatic store();
    storage_clock_o <= 1'b1;
    gap();
    storage_clock_o <= 1'b0;
    gap();
  endtask
  task automatic power_clear();
    shift_clear_n_o <= 1'b0;
    storage_clear_n_o <= 1'b0;
    gap();
    shift_clear_n_o <= 1'b1;
    storage_clear_n_o <= 1'b1;
    gap();
  endtask
  // a storage pulse while the storage clear is still low
  task automatic clear_store();
    storage_clear_n_o <= 1'b0;
    gap();
    store();
    storage_clear_n_o <= 1'b1;
    gap();
  endtask
  // a shift pulse while the clear is still low
  task automatic shift_cleared();
    shift_clear_n_o <= 1'b0;
    gap();
    shift_bit(1'b1, 1'b0);
    shift_clear_n_o <= 1'b1;
    gap();
  endtask
endmodule
`default_nettype wire

// >>> verification/test_serial_in_parallel_out_latch.sv
// self-checking bench for the serial-in parallel-out latch
// assumes sipol_top and sipol_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_serial_in_parallel_out_latch;
  logic sys_clk_i, rst_i, ce_i, hold_i, cascade_out_o, in_ready_o;
  logic serial_in, shift_clock, shift_clear_n, storage_clock, storage_clear_n;
  logic [7:0] parallel_out_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  sipol_host_model u_host (.clk_i(sys_clk_i), .serial_in_o(serial_in),
    .shift_clock_o(shift_clock), .shift_clear_n_o(shift_clear_n),
    .storage_clock_o(storage_clock), .storage_clear_n_o(storage_clear_n));
  sipol_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .serial_in_i(serial_in), .shift_clock_i(shift_clock), .shift_clear_n_i(shift_clear_n),
    .storage_clock_i(storage_clock), .storage_clear_n_i(storage_clear_n), .hold_i(hold_i),
    .parallel_out_o(parallel_out_o), .cascade_out_o(cascade_out_o), .in_ready_o(in_ready_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_load();
    u_host.power_clear();
    settle();
    check("clear word", parallel_out_o, 8'h00);
    for (int i = 7; i >= 0; i--) u_host.shift_bit(8'ha5 >> i, 1'b0);
    settle();
    check("word held", parallel_out_o, 8'h00);
    check("cascade", {7'h00, cascade_out_o}, 8'h01);
    u_host.store();
    settle();
    check("stored", parallel_out_o, 8'ha5);
    $display("test load done");
  endtask
  task automatic t_tied();
    u_host.shift_bit(1'b1, 1'b1);
    settle();
    check("tied one", parallel_out_o, 8'ha5);
    u_host.shift_bit(1'b0, 1'b1);
    settle();
    check("tied two", parallel_out_o, 8'h4b);
    u_host.shift_cleared();
    u_host.store();
    settle();
    check("shift clear", parallel_out_o, 8'h00);
    check("cascade clear", {7'h00, cascade_out_o}, 8'h00);
    $display("test tied done");
  endtask
  task automatic t_fifo();
    hold_i <= 1'b1;
    repeat (20) u_host.shift_bit(1'b1, 1'b0);
    check("full", {7'h00, in_ready_o}, 8'h00);
    check("held word", parallel_out_o, 8'h00);
    hold_i <= 1'b0;
    repeat (30) @(posedge sys_clk_i);
    check("drained", {7'h00, in_ready_o}, 8'h01);
    u_host.store();
    settle();
    check("ones", parallel_out_o, 8'hff);
    u_host.clear_store();
    settle();
    check("store clear", parallel_out_o, 8'h00);
    $display("test fifo done");
  endtask
  // a whole pulse while frozen must leave no trace
  task automatic t_freeze();
    ce_i <= 1'b0;
    u_host.shift_bit(1'b0, 1'b1);
    ce_i <= 1'b1;
    settle();
    check("frozen word", parallel_out_o, 8'h00);
    check("frozen cascade", {7'h00, cascade_out_o}, 8'h01);
    $display("test freeze done");
  endtask
  task automatic t_reset();
    u_host.store();
    settle();
    check("before reset", parallel_out_o, 8'hff);
    rst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check("reset word", parallel_out_o, 8'h00);
    check("reset cascade", {7'h00, cascade_out_o}, 8'h00);
    check("reset ready", {7'h00, in_ready_o}, 8'h00);
    rst_i <= 1'b0;
    settle();
    check("ready again", {7'h00, in_ready_o}, 8'h01);
    $display("test reset done");
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    hold_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    t_load();
    t_tied();
    t_fifo();
    t_freeze();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
